//--- hw/embp_bus_port.sv
// external memory bus port: four-phase cycle sequencer driving the memory pins
`timescale 1ns/1ps
module embp_bus_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_program,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic cycle_start,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [15:0] address_lines,
  output logic address_oe,
  output logic program_space_select_n,
  output logic data_space_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic control_oe,
  input wire logic [15:0] data_lines_in,
  output logic [15:0] data_lines_out,
  output logic data_lines_oe
);
  embp_pkg::embp_state_t s;
  embp_pkg::embp_state_t next_s;

  // ************
  // next state
  // ************
  always_comb begin
    next_s = s;
    next_s.released = 1'b1;
    next_s.rvalid = 1'b0;
    // cycle start is registered so the pin comes straight from a flip-flop
    next_s.start = 1'b0;
    // phases advance one per clock, so a cycle is always exactly four clocks
    next_s.phase = embp_pkg::embp_phase_t'(s.phase + 2'b01);
    case (s.phase)
      embp_pkg::EMBP_PHASE_THREE: begin
        // entering phase zero: launch the new access or go idle
        next_s.data_oe = 1'b0;
        next_s.start = 1'b1;
        // there is no ready: a request that misses this edge waits a whole cycle
        if (req_valid && s.released) begin
          next_s.kind = req_write ? embp_pkg::EMBP_WRITE : embp_pkg::EMBP_READ;
          next_s.prog = req_program;
          next_s.addr = req_addr;
          next_s.wdata = req_wdata;
          next_s.ps_n = ~req_program;
          next_s.ds_n = req_program;
        end else begin
          next_s.kind = embp_pkg::EMBP_IDLE;
          next_s.ps_n = 1'b1;
          next_s.ds_n = 1'b1;
        end
        next_s.rd_n = 1'b1;
        next_s.wr_n = 1'b1;
      end
      embp_pkg::EMBP_PHASE_ZERO: begin
        // entering phase one: strobe low, only one kind per cycle
        next_s.rd_n = (s.kind != embp_pkg::EMBP_READ);
        next_s.wr_n = (s.kind != embp_pkg::EMBP_WRITE);
      end
      embp_pkg::EMBP_PHASE_ONE: begin
        next_s.data_oe = (s.kind == embp_pkg::EMBP_WRITE);
      end
      embp_pkg::EMBP_PHASE_TWO: begin
        // trailing edge of phase two: sample, then strobes rise in phase three
        if (s.kind == embp_pkg::EMBP_READ) begin
          next_s.rdata = data_lines_in;
          next_s.rvalid = 1'b1;
        end
        next_s.rd_n = 1'b1;
        next_s.wr_n = 1'b1;
      end
      default: begin
        next_s.phase = embp_pkg::EMBP_PHASE_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{phase: embp_pkg::EMBP_PHASE_THREE, kind: embp_pkg::EMBP_IDLE, prog: 1'b0,
             addr: embp_pkg::ADDR_RST, wdata: embp_pkg::DATA_RST,
             rdata: embp_pkg::DATA_RST, rvalid: 1'b0, start: 1'b0, released: 1'b0,
             ps_n: 1'b1, ds_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, data_oe: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ************
  // pins, each straight from the state register
  // ************
  // bus pins float during reset; drivers come on with the first clock after release
  assign cycle_start = s.start;
  assign rd_data = s.rdata;
  assign rd_valid = s.rvalid;
  assign address_lines = s.addr;
  assign address_oe = s.released;
  assign control_oe = s.released;
  assign program_space_select_n = s.ps_n;
  assign data_space_select_n = s.ds_n;
  assign read_strobe_n = s.rd_n;
  assign write_strobe_n = s.wr_n;
  assign data_lines_out = s.wdata;
  assign data_lines_oe = s.data_oe;

  // ************
  // checks
  // ************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_phase_order: assert property (s.released |=> s.phase == $past(s.phase) + 2'b01)
    else $error("phase did not advance in order");
  a_addr_stable: assert property (s.phase != embp_pkg::EMBP_PHASE_THREE && s.released
    |=> $stable(address_lines))
    else $error("address changed outside phase zero");
  a_read_sample: assert property (s.phase == embp_pkg::EMBP_PHASE_TWO
    && s.kind == embp_pkg::EMBP_READ |=> rd_valid && rd_data == $past(data_lines_in))
    else $error("read data not captured at end of phase two");
  a_write_drive: assert property (data_lines_oe |-> s.kind == embp_pkg::EMBP_WRITE
    && (s.phase == embp_pkg::EMBP_PHASE_TWO || s.phase == embp_pkg::EMBP_PHASE_THREE))
    else $error("data driven outside phases two and three of a write");
  a_write_window: assert property (s.phase == embp_pkg::EMBP_PHASE_ONE
    && s.kind == embp_pkg::EMBP_WRITE |=> data_lines_oe ##1 data_lines_oe ##1 !data_lines_oe)
    else $error("write drive window wrong");
  a_idle_float: assert property (s.kind == embp_pkg::EMBP_IDLE |-> !data_lines_oe)
    else $error("data lines driven while idle");
  a_idle_selects: assert property (s.phase == embp_pkg::EMBP_PHASE_ZERO
    && s.kind == embp_pkg::EMBP_IDLE |-> program_space_select_n && data_space_select_n)
    else $error("select low in idle cycle");
  a_prog_select: assert property (s.phase == embp_pkg::EMBP_PHASE_THREE && s.released
    && req_valid && req_program |=> !program_space_select_n [*4])
    else $error("program select not held over access");
  a_data_select: assert property (s.phase == embp_pkg::EMBP_PHASE_THREE && s.released
    && req_valid && !req_program |=> !data_space_select_n [*4])
    else $error("data select not held over access");
  a_read_strobe: assert property (s.phase == embp_pkg::EMBP_PHASE_ZERO
    && s.kind == embp_pkg::EMBP_READ |=> !read_strobe_n [*2] ##1 read_strobe_n)
    else $error("read strobe timing wrong");
  a_write_strobe: assert property (s.phase == embp_pkg::EMBP_PHASE_ZERO
    && s.kind == embp_pkg::EMBP_WRITE |=> !write_strobe_n [*2] ##1 write_strobe_n)
    else $error("write strobe timing wrong");
  a_strobe_excl: assert property (!(~read_strobe_n && ~write_strobe_n))
    else $error("both strobes asserted");

  // ************
  // pin enables, phase and selects
  // ************
  // address and control enables follow the released flag and data enable starts off, so nothing drives before the first edge
  a_pins_driven: assert property (
    s.released |-> address_oe && control_oe)
    else $error("bus pins floating after reset");
  a_start_phase: assert property (
    s.released |-> cycle_start == (s.phase == embp_pkg::EMBP_PHASE_ZERO))
    else $error("cycle start outside phase zero");
  a_addr_load: assert property (
    s.phase == embp_pkg::EMBP_PHASE_THREE && s.released && req_valid
    |=> address_lines == $past(req_addr))
    else $error("address not loaded at phase zero");
  a_select_stable: assert property (
    s.phase != embp_pkg::EMBP_PHASE_THREE && s.released
    |=> $stable(program_space_select_n) && $stable(data_space_select_n))
    else $error("select changed inside a cycle");
  a_one_select: assert property (
    !(!program_space_select_n && !data_space_select_n))
    else $error("both space selects low");
  a_access_select: assert property (
    s.kind != embp_pkg::EMBP_IDLE |-> !(program_space_select_n && data_space_select_n))
    else $error("access without a space select");
  a_prog_kind: assert property (
    s.kind != embp_pkg::EMBP_IDLE && s.prog |-> !program_space_select_n)
    else $error("program access without program select");

  // ************
  // strobes and data lines
  // ************
  a_idle_strobes: assert property (
    s.kind == embp_pkg::EMBP_IDLE |-> read_strobe_n && write_strobe_n)
    else $error("strobe low in idle cycle");
  a_write_no_read: assert property (
    s.kind == embp_pkg::EMBP_WRITE |-> read_strobe_n)
    else $error("read strobe low in write cycle");
  a_read_no_write: assert property (
    s.kind == embp_pkg::EMBP_READ |-> write_strobe_n)
    else $error("write strobe low in read cycle");
  a_zero_strobes: assert property (
    s.phase == embp_pkg::EMBP_PHASE_ZERO |-> read_strobe_n && write_strobe_n)
    else $error("strobe low in phase zero");
  a_zero_float: assert property (
    s.phase == embp_pkg::EMBP_PHASE_ZERO |-> !data_lines_oe)
    else $error("data driven in phase zero");
  a_read_float: assert property (
    s.kind == embp_pkg::EMBP_READ |-> !data_lines_oe)
    else $error("data driven during read");
  a_write_float: assert property (
    s.phase == embp_pkg::EMBP_PHASE_THREE && s.kind == embp_pkg::EMBP_WRITE
    |=> !data_lines_oe)
    else $error("write drivers still on at phase zero");
  a_wdata_stable: assert property (
    s.phase == embp_pkg::EMBP_PHASE_TWO && data_lines_oe |=> $stable(data_lines_out))
    else $error("write data moved while driven");
  a_rdata_hold: assert property (
    !(s.phase == embp_pkg::EMBP_PHASE_TWO && s.kind == embp_pkg::EMBP_READ)
    |=> $stable(rd_data))
    else $error("read data changed outside a capture");
  a_rvalid_pulse: assert property (
    rd_valid |=> !rd_valid)
    else $error("read valid longer than one clock");
  a_rvalid_phase: assert property (
    rd_valid |-> s.phase == embp_pkg::EMBP_PHASE_THREE && s.kind == embp_pkg::EMBP_READ)
    else $error("read valid outside phase three of a read");

  // ************
  // coverage
  // ************
  c_read: cover property (s.kind == embp_pkg::EMBP_READ && rd_valid);
  c_write: cover property (s.kind == embp_pkg::EMBP_WRITE && data_lines_oe);
  c_idle: cover property (s.released && s.kind == embp_pkg::EMBP_IDLE
    && s.phase == embp_pkg::EMBP_PHASE_THREE);
  c_prog_read: cover property (rd_valid && !program_space_select_n);
  c_back_to_back: cover property (s.phase == embp_pkg::EMBP_PHASE_THREE
    && s.kind != embp_pkg::EMBP_IDLE && req_valid);
endmodule : embp_bus_port

//--- hw/embp_pkg.sv
// package of constants and types for the external memory bus port
// Functional notes
// - address lines change in phase zero and carry the access location
// - read data captured at trailing edge of phase two
// - write data drivers on at phase two start, off at next phase zero
// - data lines high impedance whenever no transfer is in progress
// - program space select low during each external program access
// - data space select low during each external data access
// - both selects return high in phase zero of idle cycles
// - write strobe low in phase one, data driven from phase two
// - write strobe returns high in phase three; memory latches then
// - read strobe low at phase zero end, data lines are inputs
// - read strobe high in phase three; captured data held inside
// - during reset all bus pins float and the port is held idle
// - every cycle runs phases zero to three in fixed order
// - one instruction cycle spans four input clocks, one per phase
package embp_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // ************
  // phase and access encodings
  // ************
  typedef enum logic [1:0] {
    EMBP_PHASE_ZERO = 2'b00,
    EMBP_PHASE_ONE = 2'b01,
    EMBP_PHASE_TWO = 2'b10,
    EMBP_PHASE_THREE = 2'b11
  } embp_phase_t;

  typedef enum logic [1:0] {
    EMBP_IDLE = 2'b00,
    EMBP_READ = 2'b01,
    EMBP_WRITE = 2'b10
  } embp_kind_t;

  typedef struct packed {
    embp_phase_t phase;
    embp_kind_t kind;
    logic prog;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic start;
    logic released;
    logic ps_n;
    logic ds_n;
    logic rd_n;
    logic wr_n;
    logic data_oe;
  } embp_state_t;
endpackage : embp_pkg

//--- verif/embp_mem_model.sv
// static memory model on the far side of the bus port
`timescale 1ns/1ps
module embp_mem_model (
  input wire logic [15:0] address_lines,
  input wire logic program_space_select_n,
  input wire logic data_space_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [15:0] bus,
  output logic [15:0] mem_q,
  output logic mem_oe
);
  logic [15:0] mem [0:15];
  logic [15:0] held = 16'h0000;
  logic sel;
  logic [3:0] idx;
  // space select is part of the index so a swapped select reads the wrong word
  assign idx = {program_space_select_n, address_lines[2:0]};
  assign sel = !program_space_select_n || !data_space_select_n;
  always @(posedge write_strobe_n) if (sel) mem[idx] <= bus;
  assign mem_oe = !read_strobe_n && sel;
  always @(mem_oe, idx) if (mem_oe) held = mem[idx];
  // released bus shows the inverse of the last word, never a stale match
  assign mem_q = mem_oe ? mem[idx] : ~held;
endmodule : embp_mem_model

//--- verif/testbench.sv
// self-checking bench for the external memory bus port
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_program = 1'b0;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000;
  logic cycle_start, rd_valid, address_oe, ps_n, ds_n, rd_n, wr_n, control_oe, data_lines_oe;
  logic mem_oe;
  logic [15:0] rd_data, address_lines, data_lines_out, data_lines_in, mem_q;
  int fail_count = 0, num_checks = 0;
  always #25 clock = ~clock;
  assign data_lines_in = data_lines_oe ? data_lines_out : mem_q;
  embp_bus_port embp_bus_port_inst (.clock, .rst, .req_valid, .req_write, .req_program,
    .req_addr, .req_wdata, .cycle_start, .rd_data, .rd_valid, .address_lines, .address_oe,
    .program_space_select_n(ps_n), .data_space_select_n(ds_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .control_oe, .data_lines_in, .data_lines_out, .data_lines_oe);
  embp_mem_model embp_mem_model_inst (.address_lines, .program_space_select_n(ps_n),
    .data_space_select_n(ds_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .bus(data_lines_in), .mem_q, .mem_oe);
  // ************
  // shared tasks
  // ************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task wait_start;
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (cycle_start !== 1'b1 && n < 9);
    if (n == 9) begin
      fail_count++;
      results;
    end
  endtask : wait_start
  task access(input logic w, input logic p, input logic [15:0] a, input logic [15:0] d);
    req_valid = 1'b1;
    req_write = w;
    req_program = p;
    req_addr = a;
    req_wdata = d;
    wait_start;
    req_valid = 1'b0;
    check(address_lines, a);
    check({ps_n, ds_n, rd_n, wr_n, data_lines_oe}, {!p, p, 3'b110});
    @(negedge clock);
    check({rd_n, wr_n, data_lines_oe}, w ? 3'h4 : 3'h2);
    @(negedge clock);
    check({rd_n, wr_n, data_lines_oe}, w ? 3'h5 : 3'h2);
    if (w) check(data_lines_out, d);
    check(mem_oe, !w);
    @(negedge clock);
    check({ps_n, ds_n, rd_n, wr_n, data_lines_oe, rd_valid}, {!p, p, 2'b11, w, !w});
    if (!w) check(rd_data, d);
  endtask : access
  task idle_cycle;
    wait_start;
    check({ps_n, ds_n, rd_n, wr_n, data_lines_oe}, 5'h1E);
    repeat (3) begin
      @(negedge clock);
      check({cycle_start, data_lines_oe, rd_n, wr_n}, 4'h3);
    end
  endtask : idle_cycle
  task mid_reset;
    req_valid = 1'b1;
    req_write = 1'b1;
    wait_start;
    @(negedge clock);
    rst = 1'b1;
    #5 check({address_oe, control_oe, data_lines_oe}, 3'h0);
    repeat (6) @(negedge clock);
    req_valid = 1'b0;
    rst = 1'b0;
    idle_cycle;
  endtask : mid_reset
  // ************
  // main sequence
  // ************
  initial begin
    repeat (6) @(negedge clock);
    check({address_oe, control_oe, data_lines_oe}, 3'h0);
    rst = 1'b0;
    idle_cycle;
    $display("test idle done");
    access(1'b1, 1'b0, 16'hFFF8, 16'hA5C3);
    access(1'b1, 1'b1, 16'h0000, 16'h5A3C);
    idle_cycle;
    access(1'b0, 1'b0, 16'hFFF8, 16'hA5C3);
    access(1'b0, 1'b1, 16'h0000, 16'h5A3C);
    $display("test traffic done");
    mid_reset;
    $display("test reset done");
    results;
  end
endmodule : testbench
